// ---- rtl/dtc_pkg.sv ----
// shared constants and types of the dual timer/counter block
package dtc_pkg;

	// timer-function prescale: one count per twelve system clocks
	localparam logic [3:0] DTC_PRESCALE_DIV  = 4'hC;
	localparam logic [3:0] DTC_PRESCALE_LAST = DTC_PRESCALE_DIV - 4'h1;

	// register indices; the byte address is four times the index
	localparam logic [7:0] DTC_IDX_RUNF = 8'h88;
	localparam logic [7:0] DTC_IDX_MODE = 8'h89;
	localparam logic [7:0] DTC_IDX_LO0  = 8'h8A;
	localparam logic [7:0] DTC_IDX_LO1  = 8'h8B;
	localparam logic [7:0] DTC_IDX_HI0  = 8'h8C;
	localparam logic [7:0] DTC_IDX_HI1  = 8'h8D;
	localparam logic [7:0] DTC_IDX_AUX  = 8'hA6;

	localparam int unsigned DTC_ADDR_W = 12;
	localparam int unsigned DTC_DATA_W = 32;
	localparam int unsigned DTC_REG_W  = 8;

	// reset values
	localparam logic [7:0] DTC_RST_BYTE = 8'h00;

	// run/flag control bit positions
	localparam int unsigned DTC_OVF1  = 7;
	localparam int unsigned DTC_RUN1  = 6;
	localparam int unsigned DTC_OVF0  = 5;
	localparam int unsigned DTC_RUN0  = 4;
	localparam int unsigned DTC_XFLG1 = 3;
	localparam int unsigned DTC_XTYP1 = 2;
	localparam int unsigned DTC_XFLG0 = 1;
	localparam int unsigned DTC_XTYP0 = 0;

	// auxiliary config bit positions and writable mask
	localparam int unsigned DTC_AUX_FAST0 = 7;
	localparam int unsigned DTC_AUX_FAST1 = 6;
	localparam int unsigned DTC_AUX_CKOE1 = 1;
	localparam int unsigned DTC_AUX_CKOE0 = 0;
	localparam logic [7:0]  DTC_AUX_MASK  = 8'hC3;

	// width of the low part of the 13-bit mode
	localparam int unsigned DTC_LO13_W = 5;

	typedef enum logic [1:0] {
		DTC_MODE_13    = 2'b00,
		DTC_MODE_16    = 2'b01,
		DTC_MODE_AR8   = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_e_t;

	// one timer's half of the mode register
	typedef struct packed {
		logic        gate;
		logic        counter_sel;
		dtc_mode_e_t mode;
	} dtc_tmode_t;

	// result of one count step
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
		logic       ovf;
	} dtc_cnt_t;

endpackage

// ---- rtl/dtc_event_src.sv ----
// count-enable source of one timer: prescaled ticks or pin falling edges
module dtc_event_src
	import dtc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic rate_tick,
	input  wire logic counter_sel,
	input  wire logic pin_sync,
	input  wire logic run_ok,
	output logic      inc
);

	logic prev_q;
	logic prev_d;
	logic edge_q;
	logic edge_d;

	// pin sampled once per timer-rate cycle; high then low is an edge
	assign prev_d = rate_tick ? pin_sync : prev_q;
	// a found edge is counted at the end of the following rate cycle
	assign edge_d = rate_tick ? (prev_q & ~pin_sync) : edge_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			edge_q <= edge_d;
		end
	end

	assign inc = rate_tick & run_ok & (counter_sel ? edge_q : 1'b1);

endmodule

// ---- rtl/dtc_dual_timer.sv ----
// dual 16-bit timer/counter with apb register access
// Contract
// - timer function counts every twelve clocks
// - fast select bit counts every clock
// - counter samples pin, counts high-then-low
// - counted value appears one rate cycle later
// - mode 0 is 13-bit, sets overflow flag
// - count only if run and gate allows, except timer 1 while timer 0 is in mode 3
// - mode 1 is full 16-bit counter
// - mode 2 low counts, reloads from high
// - timer 1 in mode 3 holds count
// - timer 0 mode 3 low half own controls
// - high half timer only, timer 1 run/flag
// - two mode bits per timer select mode
// - function select: clock or count pin
// - overflow flag set, cleared on vectoring
// - external flag set; edge mode clears on vector
// - type bit: low level or falling edge
// - aux bits 7/6 pick divided or full clock
// - aux bits 0/1 enable clock outputs
// - timer 1 high count register, resets zero
module dtc_dual_timer
	import dtc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [DTC_ADDR_W-1:0] paddr,
	input  wire logic [DTC_DATA_W-1:0] pwdata,
	output logic      [DTC_DATA_W-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  ext_irq0_pin,
	input  wire logic                  ext_irq1_pin,
	input  wire logic                  timer0_count_pin,
	input  wire logic                  timer1_count_pin,
	input  wire logic                  timer0_irq_ack,
	input  wire logic                  timer1_irq_ack,
	input  wire logic                  ext_irq0_ack,
	input  wire logic                  ext_irq1_ack,
	output logic                       timer0_overflow_flag,
	output logic                       timer1_overflow_flag,
	output logic                       ext_irq0_flag,
	output logic                       ext_irq1_flag,
	output logic                       timer0_clock_out,
	output logic                       timer1_clock_out
);

	localparam int unsigned NPIN = 4;
	localparam int unsigned PIN_EXT_IRQ0_PIN = 0;
	localparam int unsigned PIN_EXT_IRQ1_PIN = 1;
	localparam int unsigned PIN_CNT0 = 2;
	localparam int unsigned PIN_CNT1 = 3;

	// byte addresses from register indices
	localparam logic [DTC_ADDR_W-1:0] A_RUNF = {2'h0, DTC_IDX_RUNF, 2'h0};
	localparam logic [DTC_ADDR_W-1:0] A_MODE = {2'h0, DTC_IDX_MODE, 2'h0};
	localparam logic [DTC_ADDR_W-1:0] A_LO0  = {2'h0, DTC_IDX_LO0, 2'h0};
	localparam logic [DTC_ADDR_W-1:0] A_LO1  = {2'h0, DTC_IDX_LO1, 2'h0};
	localparam logic [DTC_ADDR_W-1:0] A_HI0  = {2'h0, DTC_IDX_HI0, 2'h0};
	localparam logic [DTC_ADDR_W-1:0] A_HI1  = {2'h0, DTC_IDX_HI1, 2'h0};
	localparam logic [DTC_ADDR_W-1:0] A_AUX  = {2'h0, DTC_IDX_AUX, 2'h0};

	// ---------------- registers ----------------
	logic [7:0] timer_run_flag_control_q;
	logic [7:0] timer_run_flag_control_d;
	logic [7:0] timer_mode_control_q;
	logic [7:0] timer_mode_control_d;
	logic [7:0] timer0_count_low_q;
	logic [7:0] timer0_count_low_d;
	logic [7:0] timer0_count_high_q;
	logic [7:0] timer0_count_high_d;
	logic [7:0] timer1_count_low_q;
	logic [7:0] timer1_count_low_d;
	logic [7:0] timer1_count_high_q;
	logic [7:0] timer1_count_high_d;
	logic [7:0] auxiliary_timer_config_q;
	logic [7:0] auxiliary_timer_config_d;

	logic                  pready_q;
	logic                  pready_d;
	logic                  pslverr_q;
	logic                  pslverr_d;
	logic [DTC_DATA_W-1:0] prdata_q;
	logic [DTC_DATA_W-1:0] prdata_d;

	logic [NPIN-1:0] sync1_q;
	logic [NPIN-1:0] sync2_q;
	logic [1:0]      int_prev_q;
	logic [3:0]      pre_q;
	logic [3:0]      pre_d;
	logic            ck0_q;
	logic            ck0_d;
	logic            ck1_q;
	logic            ck1_d;

	// ---------------- apb decode ----------------
	logic       access;
	logic       wr_en;
	logic       sel_runf;
	logic       sel_mode;
	logic       sel_lo0;
	logic       sel_lo1;
	logic       sel_hi0;
	logic       sel_hi1;
	logic       sel_aux;
	logic       mapped;
	logic [7:0] wbyte;
	logic [7:0] rbyte;

	assign access   = psel & penable;
	assign wr_en    = access & pwrite & pready_q;
	assign wbyte    = pwdata[DTC_REG_W-1:0];
	assign sel_runf = (paddr == A_RUNF);
	assign sel_mode = (paddr == A_MODE);
	assign sel_lo0  = (paddr == A_LO0);
	assign sel_lo1  = (paddr == A_LO1);
	assign sel_hi0  = (paddr == A_HI0);
	assign sel_hi1  = (paddr == A_HI1);
	assign sel_aux  = (paddr == A_AUX);
	assign mapped   = sel_runf | sel_mode | sel_lo0 | sel_lo1 | sel_hi0 | sel_hi1 | sel_aux;

	assign rbyte = sel_runf ? timer_run_flag_control_q :
	               sel_mode ? timer_mode_control_q :
	               sel_lo0  ? timer0_count_low_q :
	               sel_lo1  ? timer1_count_low_q :
	               sel_hi0  ? timer0_count_high_q :
	               sel_hi1  ? timer1_count_high_q :
	               sel_aux  ? auxiliary_timer_config_q : DTC_RST_BYTE;

	// one wait state: pready rises the cycle after the access phase opens
	assign pready_d  = access & ~pready_q;
	assign pslverr_d = access & ~pready_q & ~mapped;
	// read data holds until the next read
	assign prdata_d  = (access & ~pready_q & ~pwrite) ? {24'h000000, rbyte} : prdata_q;

	// ---------------- configuration fields ----------------
	dtc_tmode_t  tm0;
	dtc_tmode_t  tm1;
	logic        run0;
	logic        run1;
	logic        xtyp0;
	logic        xtyp1;
	logic        fast0;
	logic        fast1;
	logic        ckoe0;
	logic        ckoe1;
	logic        split0;
	logic        ext_irq0_pin_s;
	logic        ext_irq1_pin_s;

	assign tm1    = dtc_tmode_t'(timer_mode_control_q[7:4]);
	assign tm0    = dtc_tmode_t'(timer_mode_control_q[3:0]);
	assign run0   = timer_run_flag_control_q[DTC_RUN0];
	assign run1   = timer_run_flag_control_q[DTC_RUN1];
	assign xtyp0  = timer_run_flag_control_q[DTC_XTYP0];
	assign xtyp1  = timer_run_flag_control_q[DTC_XTYP1];
	assign fast0  = auxiliary_timer_config_q[DTC_AUX_FAST0];
	assign fast1  = auxiliary_timer_config_q[DTC_AUX_FAST1];
	assign ckoe0  = auxiliary_timer_config_q[DTC_AUX_CKOE0];
	assign ckoe1  = auxiliary_timer_config_q[DTC_AUX_CKOE1];
	assign split0 = (tm0.mode == DTC_MODE_SPLIT);
	assign ext_irq0_pin_s = sync2_q[PIN_EXT_IRQ0_PIN];
	assign ext_irq1_pin_s = sync2_q[PIN_EXT_IRQ1_PIN];

	// ---------------- timer rate ----------------
	logic       tick12;
	logic [1:0] rate_tick;
	logic [1:0] run_ok;
	logic [1:0] counter_sel;
	logic [1:0] pin_sync;
	logic [1:0] inc;

	assign tick12 = (pre_q == DTC_PRESCALE_LAST);
	assign pre_d  = tick12 ? 4'h0 : pre_q + 4'h1;
	assign rate_tick[0] = fast0 | tick12;
	assign rate_tick[1] = fast1 | tick12;

	// timer 1 runs free while timer 0 borrows its run bit in split mode
	assign run_ok[0] = run0 & (~tm0.gate | ext_irq0_pin_s);
	assign run_ok[1] = (tm1.mode != DTC_MODE_SPLIT) &
	                   (split0 | (run1 & (~tm1.gate | ext_irq1_pin_s)));
	assign counter_sel = {tm1.counter_sel, tm0.counter_sel};
	assign pin_sync    = {sync2_q[PIN_CNT1], sync2_q[PIN_CNT0]};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_src
			dtc_event_src u_src (
				.clk         (clk),
				.rst_n       (rst_n),
				.rate_tick   (rate_tick[gi]),
				.counter_sel (counter_sel[gi]),
				.pin_sync    (pin_sync[gi]),
				.run_ok      (run_ok[gi]),
				.inc         (inc[gi])
			);
		end
	endgenerate

	// ---------------- count step ----------------
	function automatic dtc_cnt_t count_step(
		input dtc_mode_e_t m,
		input logic [7:0]  lo,
		input logic [7:0]  hi,
		input logic        step
	);
		dtc_cnt_t    r;
		logic [16:0] s;
		r.hi  = hi;
		r.lo  = lo;
		r.ovf = 1'b0;
		s     = 17'h00000;
		if (step) begin
			unique case (m)
				DTC_MODE_13: begin
					s     = {4'h0, hi, lo[DTC_LO13_W-1:0]} + 17'h00001;
					r.hi  = s[DTC_LO13_W+7:DTC_LO13_W];
					r.lo  = {lo[7:DTC_LO13_W], s[DTC_LO13_W-1:0]};
					r.ovf = s[DTC_LO13_W+8];
				end
				DTC_MODE_16: begin
					s     = {1'b0, hi, lo} + 17'h00001;
					r.hi  = s[15:8];
					r.lo  = s[7:0];
					r.ovf = s[16];
				end
				DTC_MODE_AR8: begin
					s     = {9'h000, lo} + 17'h00001;
					r.lo  = s[8] ? hi : s[7:0];
					r.ovf = s[8];
				end
				DTC_MODE_SPLIT: begin
					s     = {9'h000, lo} + 17'h00001;
					r.lo  = s[7:0];
					r.ovf = s[8];
				end
			endcase
		end
		return r;
	endfunction

	dtc_cnt_t   step0;
	dtc_cnt_t   step1;
	logic       th_inc;
	logic [8:0] th_sum;
	logic       th_ovf;
	logic       ovf0;
	logic       ovf1;

	assign step0 = count_step(tm0.mode, timer0_count_low_q, timer0_count_high_q, inc[0]);
	assign step1 = count_step(tm1.mode, timer1_count_low_q, timer1_count_high_q, inc[1]);

	// split high half: timer function only, started by timer 1's run bit
	assign th_inc = split0 & run1 & rate_tick[0];
	assign th_sum = {1'b0, timer0_count_high_q} + {8'h00, th_inc};
	assign th_ovf = th_sum[8];

	assign ovf0 = step0.ovf;
	assign ovf1 = split0 ? th_ovf : step1.ovf;

	// software writes win over the step in the same cycle
	assign timer0_count_low_d  = (wr_en & sel_lo0) ? wbyte : step0.lo;
	assign timer0_count_high_d = (wr_en & sel_hi0) ? wbyte :
	                             split0 ? th_sum[7:0] : step0.hi;
	assign timer1_count_low_d  = (wr_en & sel_lo1) ? wbyte : step1.lo;
	assign timer1_count_high_d = (wr_en & sel_hi1) ? wbyte : step1.hi;

	assign timer_mode_control_d     = (wr_en & sel_mode) ? wbyte : timer_mode_control_q;
	assign auxiliary_timer_config_d = (wr_en & sel_aux) ? (wbyte & DTC_AUX_MASK) :
	                                  auxiliary_timer_config_q;

	// ---------------- run/flag control ----------------
	logic       wr_runf;
	logic [1:0] int_fall;
	logic       xflg0_hold;
	logic       xflg1_hold;

	assign wr_runf  = wr_en & sel_runf;
	assign int_fall = int_prev_q & ~{ext_irq1_pin_s, ext_irq0_pin_s};

	// overflow flags: set wins over a same-cycle software or vector clear
	assign timer_run_flag_control_d[DTC_OVF1] = ovf1 |
		(wr_runf ? wbyte[DTC_OVF1] :
		 (timer_run_flag_control_q[DTC_OVF1] & ~timer1_irq_ack));
	assign timer_run_flag_control_d[DTC_OVF0] = ovf0 |
		(wr_runf ? wbyte[DTC_OVF0] :
		 (timer_run_flag_control_q[DTC_OVF0] & ~timer0_irq_ack));

	assign timer_run_flag_control_d[DTC_RUN1] = wr_runf ? wbyte[DTC_RUN1] : run1;
	assign timer_run_flag_control_d[DTC_RUN0] = wr_runf ? wbyte[DTC_RUN0] : run0;
	assign timer_run_flag_control_d[DTC_XTYP1] = wr_runf ? wbyte[DTC_XTYP1] : xtyp1;
	assign timer_run_flag_control_d[DTC_XTYP0] = wr_runf ? wbyte[DTC_XTYP0] : xtyp0;

	// edge mode keeps the flag until vectored; level mode follows the pin
	assign xflg1_hold = wr_runf ? wbyte[DTC_XFLG1] :
	                    (timer_run_flag_control_q[DTC_XFLG1] & ~ext_irq1_ack);
	assign xflg0_hold = wr_runf ? wbyte[DTC_XFLG0] :
	                    (timer_run_flag_control_q[DTC_XFLG0] & ~ext_irq0_ack);
	assign timer_run_flag_control_d[DTC_XFLG1] = xtyp1 ?
	                                             (int_fall[1] | xflg1_hold) : ~ext_irq1_pin_s;
	assign timer_run_flag_control_d[DTC_XFLG0] = xtyp0 ?
	                                             (int_fall[0] | xflg0_hold) : ~ext_irq0_pin_s;

	// ---------------- clock outputs ----------------
	assign ck0_d = ckoe0 & (ck0_q ^ ovf0);
	assign ck1_d = ckoe1 & (ck1_q ^ ovf1);

	// ---------------- flip-flops ----------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// idle-high reset: no false level request or edge after release
			sync1_q    <= '1;
			sync2_q    <= '1;
			int_prev_q <= '1;
		end else begin
			sync1_q    <= {timer1_count_pin, timer0_count_pin, ext_irq1_pin, ext_irq0_pin};
			sync2_q    <= sync1_q;
			int_prev_q <= {ext_irq1_pin_s, ext_irq0_pin_s};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_run_flag_control_q <= DTC_RST_BYTE;
			timer_mode_control_q     <= DTC_RST_BYTE;
			auxiliary_timer_config_q <= DTC_RST_BYTE;
		end else begin
			timer_run_flag_control_q <= timer_run_flag_control_d;
			timer_mode_control_q     <= timer_mode_control_d;
			auxiliary_timer_config_q <= auxiliary_timer_config_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer0_count_low_q  <= DTC_RST_BYTE;
			timer0_count_high_q <= DTC_RST_BYTE;
			timer1_count_low_q  <= DTC_RST_BYTE;
			timer1_count_high_q <= DTC_RST_BYTE;
		end else begin
			timer0_count_low_q  <= timer0_count_low_d;
			timer0_count_high_q <= timer0_count_high_d;
			timer1_count_low_q  <= timer1_count_low_d;
			timer1_count_high_q <= timer1_count_high_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q     <= 4'h0;
			ck0_q     <= 1'b0;
			ck1_q     <= 1'b0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pre_q     <= pre_d;
			ck0_q     <= ck0_d;
			ck1_q     <= ck1_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
		end
	end

	// ---------------- outputs ----------------
	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign timer0_overflow_flag = timer_run_flag_control_q[DTC_OVF0];
	assign timer1_overflow_flag = timer_run_flag_control_q[DTC_OVF1];
	assign ext_irq0_flag        = timer_run_flag_control_q[DTC_XFLG0];
	assign ext_irq1_flag        = timer_run_flag_control_q[DTC_XFLG1];
	assign timer0_clock_out     = ck0_q;
	assign timer1_clock_out     = ck1_q;

endmodule

// ---- bench/dtc_monitor.sv ----
// concurrent checks on the dual timer/counter top-level ports
module dtc_monitor
	import dtc_pkg::*;
(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [DTC_ADDR_W-1:0] paddr,
	input wire logic [DTC_DATA_W-1:0] prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  timer0_irq_ack,
	input wire logic                  timer1_irq_ack,
	input wire logic                  timer0_overflow_flag,
	input wire logic                  timer1_overflow_flag,
	input wire logic                  timer0_clock_out,
	input wire logic                  timer1_clock_out
);
	wire logic mapped;
	wire logic wr_done;
	assign mapped = paddr inside {12'h220, 12'h224, 12'h228, 12'h22C, 12'h230, 12'h234, 12'h298};
	assign wr_done = psel && penable && pready && pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ready_wait; psel && penable && !pready |=> pready; endproperty
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_ready_access; pready |-> psel && penable; endproperty
	property p_err_decode; pready |-> (pslverr == !mapped); endproperty
	property p_upper_zero; pready |-> prdata[31:8] == 24'h000000; endproperty
	property p_rdata_hold; !$stable(prdata) |-> pready && !pwrite; endproperty
	property p_ck0_rise; $rose(timer0_clock_out) |-> timer0_overflow_flag; endproperty
	property p_ck1_rise; $rose(timer1_clock_out) |-> timer1_overflow_flag; endproperty
	property p_tf0_fall;
		$fell(timer0_overflow_flag) |-> $past(timer0_irq_ack) || $past(wr_done);
	endproperty
	property p_tf1_fall;
		$fell(timer1_overflow_flag) |-> $past(timer1_irq_ack) || $past(wr_done);
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready late");
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
	a_ready_access: assert property (p_ready_access) else $error("ready outside access");
	a_err_decode: assert property (p_err_decode) else $error("bad error decode");
	a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	a_ck0_rise: assert property (p_ck0_rise) else $error("clock out 0 rose");
	a_ck1_rise: assert property (p_ck1_rise) else $error("clock out 1 rose");
	a_tf0_fall: assert property (p_tf0_fall) else $error("flag 0 fell alone");
	a_tf1_fall: assert property (p_tf1_fall) else $error("flag 1 fell alone");
	c_ovf0: cover property ($rose(timer0_overflow_flag));
	c_ck0: cover property ($rose(timer0_clock_out));
	c_err: cover property (pslverr);
endmodule

bind dtc_dual_timer dtc_monitor mon_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .timer0_irq_ack, .timer1_irq_ack, .timer0_overflow_flag,
	.timer1_overflow_flag, .timer0_clock_out, .timer1_clock_out);

// ---- bench/tb_top.sv ----
// self-checking testbench of the dual timer/counter
module tb_top
	import dtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] A_RUNF = 12'h220, A_MODE = 12'h224, A_LO0 = 12'h228;
	localparam logic [11:0] A_LO1 = 12'h22C, A_HI0 = 12'h230, A_HI1 = 12'h234;
	localparam logic [11:0] A_AUX = 12'h298;
	logic                  clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [DTC_ADDR_W-1:0] paddr;
	logic [DTC_DATA_W-1:0] pwdata, prdata;
	logic                  ext_irq0_pin, ext_irq1_pin, timer0_count_pin, timer1_count_pin;
	logic                  timer0_irq_ack, timer1_irq_ack, ext_irq0_ack, ext_irq1_ack;
	logic                  timer0_overflow_flag, timer1_overflow_flag, ext_irq0_flag;
	logic                  ext_irq1_flag, timer0_clock_out, timer1_clock_out;
	int                    err_total, n_checks, cyc;

	dtc_dual_timer dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ext_irq0_pin, .ext_irq1_pin, .timer0_count_pin, .timer1_count_pin,
		.timer0_irq_ack, .timer1_irq_ack, .ext_irq0_ack, .ext_irq1_ack, .timer0_overflow_flag,
		.timer1_overflow_flag, .ext_irq0_flag, .ext_irq1_flag, .timer0_clock_out,
		.timer1_clock_out);

	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		v = r[7:0];
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		chk(nm, {e, r}, {9'h000, exp});
	endtask

	// cycles between two changes of clock out 0
	task automatic per(input int exp);
		logic p;
		int n;
		n = 0;
		p = timer0_clock_out;
		while (timer0_clock_out === p && n < 100) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		p = timer0_clock_out;
		while (timer0_clock_out === p && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("ck0_period", n, exp);
	endtask

	task automatic t_reset;
		logic [31:0] r;
		logic e;
		rdc("mode", A_MODE, 8'h00);
		rdc("runf", A_RUNF, 8'h00);
		rdc("lo0", A_LO0, 8'h00);
		rdc("hi0", A_HI0, 8'h00);
		rdc("lo1", A_LO1, 8'h00);
		rdc("hi1", A_HI1, 8'h00);
		rdc("aux", A_AUX, 8'h00);
		apb(1'b0, 12'h23C, 8'h00, r, e);
		chk("unmapped", {e, r}, 33'h100000000);
		wr(A_AUX, 8'hFF);
		rdc("aux_mask", A_AUX, 8'hC3);
		wr(A_HI1, 8'hA5);
		rdc("hi1_rw", A_HI1, 8'hA5);
		wr(A_AUX, 8'h00);
		$display("test reset_regs done");
	endtask

	task automatic t_modes;
		logic [7:0] md[4] = '{8'h00, 8'h01, 8'h02, 8'h03};
		logic [7:0] li[4] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF};
		logic [7:0] hi[4] = '{8'hFF, 8'hFF, 8'h5A, 8'h11};
		logic [7:0] lx[4] = '{8'hE0, 8'h00, 8'h5A, 8'h00};
		logic [7:0] hx[4] = '{8'h00, 8'h00, 8'h5A, 8'h11};
		int n;
		for (int i = 0; i < 4; i++) begin
			wr(A_RUNF, 8'h00);
			wr(A_MODE, md[i]);
			wr(A_LO0, li[i]);
			wr(A_HI0, hi[i]);
			wr(A_RUNF, 8'h10);
			n = 0;
			while (timer0_overflow_flag !== 1'b1 && n < 100) begin
				@(posedge clk);
				n++;
			end
			chk("tf0_set", timer0_overflow_flag, 1'b1);
			wr(A_RUNF, 8'h00);
			rdc("lo_after", A_LO0, lx[i]);
			rdc("hi_after", A_HI0, hx[i]);
		end
		$display("test modes done");
	endtask

	task automatic t_rate;
		wr(A_MODE, 8'h02);
		wr(A_HI0, 8'hFE);
		wr(A_LO0, 8'hFE);
		wr(A_AUX, 8'h01);
		wr(A_RUNF, 8'h10);
		per(24);
		wr(A_AUX, 8'h81);
		per(2);
		wr(A_RUNF, 8'h00);
		wr(A_AUX, 8'h00);
		tick(3);
		chk("ck_off", {timer1_clock_out, timer0_clock_out}, 2'b00);
		$display("test rate done");
	endtask

	task automatic t_count;
		logic [7:0] v;
		wr(A_MODE, 8'h05);
		wr(A_LO0, 8'h00);
		wr(A_RUNF, 8'h10);
		repeat (5) begin
			timer0_count_pin <= 1'b0;
			tick(30);
			timer0_count_pin <= 1'b1;
			tick(30);
		end
		wr(A_RUNF, 8'h00);
		rdc("events", A_LO0, 8'h05);
		wr(A_MODE, 8'h09);
		wr(A_LO0, 8'h00);
		ext_irq0_pin <= 1'b0;
		wr(A_RUNF, 8'h10);
		tick(60);
		wr(A_RUNF, 8'h00);
		rdc("gated", A_LO0, 8'h00);
		ext_irq0_pin <= 1'b1;
		wr(A_RUNF, 8'h10);
		tick(60);
		wr(A_RUNF, 8'h00);
		rd(A_LO0, v);
		chk("gate_open", v != 8'h00, 1'b1);
		wr(A_MODE, 8'h31);
		wr(A_LO1, 8'h33);
		wr(A_RUNF, 8'h40);
		tick(60);
		wr(A_RUNF, 8'h00);
		rdc("t1_hold", A_LO1, 8'h33);
		wr(A_MODE, 8'h03);
		wr(A_AUX, 8'h80);
		wr(A_HI0, 8'hFF);
		wr(A_RUNF, 8'h40);
		tick(2);
		chk("split_tf1", timer1_overflow_flag, 1'b1);
		wr(A_RUNF, 8'h00);
		wr(A_AUX, 8'h00);
		$display("test count done");
	endtask

	task automatic t_flags;
		wr(A_RUNF, 8'hA0);
		chk("tf_sw", {timer1_overflow_flag, timer0_overflow_flag}, 2'b11);
		timer0_irq_ack <= 1'b1;
		timer1_irq_ack <= 1'b1;
		tick(1);
		timer0_irq_ack <= 1'b0;
		timer1_irq_ack <= 1'b0;
		tick(2);
		chk("tf_ack", {timer1_overflow_flag, timer0_overflow_flag}, 2'b00);
		wr(A_RUNF, 8'h05);
		ext_irq0_pin <= 1'b0;
		ext_irq1_pin <= 1'b0;
		tick(6);
		chk("ie_edge", {ext_irq1_flag, ext_irq0_flag}, 2'b11);
		ext_irq0_ack <= 1'b1;
		ext_irq1_ack <= 1'b1;
		tick(1);
		ext_irq0_ack <= 1'b0;
		ext_irq1_ack <= 1'b0;
		tick(2);
		chk("ie_edge_ack", {ext_irq1_flag, ext_irq0_flag}, 2'b00);
		wr(A_RUNF, 8'h00);
		tick(5);
		chk("ie_level", {ext_irq1_flag, ext_irq0_flag}, 2'b11);
		ext_irq0_ack <= 1'b1;
		ext_irq1_ack <= 1'b1;
		tick(1);
		ext_irq0_ack <= 1'b0;
		ext_irq1_ack <= 1'b0;
		tick(2);
		chk("ie_level_ack", {ext_irq1_flag, ext_irq0_flag}, 2'b11);
		ext_irq0_pin <= 1'b1;
		ext_irq1_pin <= 1'b1;
		tick(6);
		chk("ie_level_off", {ext_irq1_flag, ext_irq0_flag}, 2'b00);
		$display("test flags done");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard, well above the thousand or so cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude;
		end
	end

	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		{timer0_irq_ack, timer1_irq_ack, ext_irq0_ack, ext_irq1_ack} = 4'h0;
		{ext_irq0_pin, ext_irq1_pin, timer0_count_pin, timer1_count_pin} = 4'hF;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		tick(4);
		t_reset;
		t_modes;
		t_rate;
		t_count;
		t_flags;
		conclude;
	end
endmodule
